// ==== rtl/pbl_port.sv ====
// top of the lower-nibble port pins: registers, pin mux, pad flops
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pbl_defines.svh"

module pbl_port #(
  parameter logic [3:0] PARALLEL_MASK = 4'hE, // pins with parallel outputs
  parameter logic [3:0] DEBUG_MASK = 4'hF // pins shared with debug
) (
  input wire logic i_clk, // system clock, 125 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic [`PBL_ADDR_W-1:0] i_addr, // register address
  input wire logic [`PBL_DATA_W-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [`PBL_DATA_W-1:0] o_rdata, // read data
  input wire logic [3:0] i_pin_in, // pad input levels
  output logic [3:0] o_pin_out, // pad output levels
  output logic [3:0] o_pin_oe, // pad output enables, high drives
  output logic [3:0] o_pullup_en, // weak pull-up enables
  output logic [3:0] o_analog_en, // analog path select
  input wire logic [3:0] i_periph_out, // remapped peripheral outputs
  output logic [3:0] o_periph_in, // remapped peripheral inputs
  input wire logic [3:0] i_parallel_en, // parallel port owns the pin
  input wire logic [3:0] i_parallel_out, // parallel address/byte enable
  input wire logic i_debug_en // programming or debug active
);

  pbl_pkg::pbl_cfg_type cfg;
  pbl_pkg::pbl_func_type func;
  pbl_pkg::pbl_pad_type pad_nxt;
  pbl_pkg::pbl_pad_type pad_r;
  logic [3:0] pin_rd;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  pbl_regs u_regs (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_pin_rd(pin_rd),
    .o_rdata(o_rdata),
    .o_cfg(cfg)
  );

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  always_comb begin
    func.periph_out = i_periph_out;
    func.parallel_en = i_parallel_en;
    func.parallel_out = i_parallel_out;
    func.debug_en = i_debug_en;
  end

  pbl_pin_mux #(
    .PARALLEL_MASK(PARALLEL_MASK),
    .DEBUG_MASK(DEBUG_MASK)
  ) u_mux (
    .i_cfg(cfg),
    .i_func(func),
    .i_pin_in(i_pin_in),
    .o_pad(pad_nxt),
    .o_pin_rd(pin_rd)
  );

  // ----------------------------------------------------------------
  // pad flops, every pad output comes from here; o_rdata comes from the register file
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pad_r.pin_out <= `PBL_RST_OUT;
      pad_r.pin_oe <= `PBL_RST_OE;
      pad_r.pullup_en <= `PBL_RST_PU;
      pad_r.analog_en <= `PBL_RST_ANA;
      pad_r.periph_in <= `PBL_RST_PIN;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign o_pin_out = pad_r.pin_out;
  assign o_pin_oe = pad_r.pin_oe;
  assign o_pullup_en = pad_r.pullup_en;
  assign o_analog_en = pad_r.analog_en;
  assign o_periph_in = pad_r.periph_in;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [3:0] dbg_m;
  logic [3:0] par_m;
  logic [3:0] plain_m;
  logic [3:0] remap_out_m;
  logic [3:0] remap_in_m;
  logic [3:0] in_m;
  logic [3:0] plain_ana_m;

  always_comb begin
    dbg_m = i_debug_en ? DEBUG_MASK : 4'h0;
    par_m = i_parallel_en & PARALLEL_MASK & ~dbg_m;
    plain_m = ~cfg.port_direction & ~cfg.remap_select & ~par_m & ~dbg_m;
    remap_out_m = ~cfg.port_direction & cfg.remap_select & ~par_m & ~dbg_m;
    remap_in_m = cfg.port_direction & cfg.remap_select & ~par_m & ~dbg_m;
    in_m = cfg.port_direction & ~par_m;
    plain_ana_m = plain_m & ~cfg.analog_config_high;
  end

  sequence s_pin_read;
    i_rd && (i_addr == `PBL_ADDR_PIN);
  endsequence

  sequence s_read_answer;
    s_pin_read ##1 1'b1;
  endsequence

  property p_input_read;
    @(posedge i_clk) disable iff (!i_resetn)
    s_read_answer |->
      o_rdata[3:0] == ($past(i_pin_in) & $past(cfg.analog_config_high)
        & ~$past(dbg_m));
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("pin input read does not match the pad level");

  property p_analog_gate;
    @(posedge i_clk) disable iff (!i_resetn)
    s_read_answer |->
      (o_rdata[3:0] & ~$past(cfg.analog_config_high)) == 4'h0;
  endproperty
  a_analog_gate: assert property (p_analog_gate)
    else $error("analog pin leaked a digital level into a read");

  property p_analog_reads_zero;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_rd && (i_addr == `PBL_ADDR_PIN) &&
      (cfg.analog_config_high == `PBL_RST_DIG)) |=>
      o_rdata == `PBL_RST_RDATA;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog port bits did not read as zero");

  property p_drive_latch;
    @(posedge i_clk) disable iff (!i_resetn)
    (plain_m != 4'h0) |=>
      ((o_pin_out ^ $past(cfg.port_output_latch)) & $past(plain_m)) == 4'h0
      && (o_pin_oe & $past(plain_m)) == $past(plain_m);
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("output pin not driven from its latch");

  property p_pullup_on;
    @(posedge i_clk) disable iff (!i_resetn)
    (!cfg.pullup_disable_n && !i_debug_en && par_m == 4'h0) |=>
      o_pullup_en == $past(cfg.port_direction);
  endproperty
  a_pullup_on: assert property (p_pullup_on)
    else $error("pull-up missing on an input pin");

  property p_pullup_off_output;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_pin_oe & o_pullup_en) == 4'h0;
  endproperty
  a_pullup_off_output: assert property (p_pullup_off_output)
    else $error("pull-up left on a driven pin");

  property p_reset_defaults;
    @(posedge i_clk) disable iff (!i_resetn)
    !$past(i_resetn) |->
      o_analog_en == `PBL_RST_ANA && o_pullup_en == `PBL_RST_PU;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("pins not analog without pull-ups after reset");

  property p_pullup_disabled;
    @(posedge i_clk) disable iff (!i_resetn)
    cfg.pullup_disable_n |=> o_pullup_en == 4'h0;
  endproperty
  a_pullup_disabled: assert property (p_pullup_disabled)
    else $error("pull-up on while pull-ups disabled");

  sequence s_debug_held;
    i_debug_en [*2];
  endsequence

  property p_debug_off;
    @(posedge i_clk) disable iff (!i_resetn)
    s_debug_held |->
      (o_pin_oe & DEBUG_MASK) == 4'h0 &&
      (o_pullup_en & DEBUG_MASK) == 4'h0 &&
      (o_periph_in & DEBUG_MASK) == 4'h0 &&
      (o_analog_en & DEBUG_MASK) == 4'h0;
  endproperty
  a_debug_off: assert property (p_debug_off)
    else $error("shared function active during debug");

  property p_parallel_override;
    @(posedge i_clk) disable iff (!i_resetn)
    (par_m != 4'h0) |=>
      (o_pin_oe & $past(par_m)) == $past(par_m) &&
      ((o_pin_out ^ $past(i_parallel_out)) & $past(par_m)) == 4'h0;
  endproperty
  a_parallel_override: assert property (p_parallel_override)
    else $error("parallel output did not override direction");

  property p_remap_out;
    @(posedge i_clk) disable iff (!i_resetn)
    (remap_out_m != 4'h0) |=>
      ((o_pin_out ^ $past(i_periph_out)) & $past(remap_out_m)) == 4'h0
      && (o_pin_oe & $past(remap_out_m)) == $past(remap_out_m);
  endproperty
  a_remap_out: assert property (p_remap_out)
    else $error("remapped output not driven by the peripheral");

  property p_remap_in;
    @(posedge i_clk) disable iff (!i_resetn)
    (remap_in_m != 4'h0) |=>
      (o_periph_in & $past(remap_in_m)) ==
        ($past(i_pin_in) & $past(cfg.analog_config_high)
          & $past(remap_in_m))
      && (o_pin_oe & $past(remap_in_m)) == 4'h0;
  endproperty
  a_remap_in: assert property (p_remap_in)
    else $error("remapped input not routed to the peripheral");

  // ----------------------------------------------------------------
  // reset, analog, input, debug, parallel and idle assertions
  // ----------------------------------------------------------------
  property p_oe_after_reset;
    @(posedge i_clk) disable iff (!i_resetn)
    !$past(i_resetn) |->
      o_pin_oe == `PBL_RST_OE && o_periph_in == `PBL_RST_PIN;
  endproperty
  a_oe_after_reset: assert property (p_oe_after_reset)
    else $error("pins not released as inputs after reset");

  property p_analog_select;
    @(posedge i_clk) disable iff (!i_resetn)
    i_resetn |=>
      o_analog_en == (~$past(cfg.analog_config_high) & ~$past(dbg_m));
  endproperty
  a_analog_select: assert property (p_analog_select)
    else $error("analog select does not follow the configuration");

  property p_analog_keeps_drive;
    @(posedge i_clk) disable iff (!i_resetn)
    (plain_ana_m != 4'h0) |=>
      ((o_pin_out ^ $past(cfg.port_output_latch)) & $past(plain_ana_m))
        == 4'h0;
  endproperty
  a_analog_keeps_drive: assert property (p_analog_keeps_drive)
    else $error("analog setting altered a driven pin");

  property p_input_no_drive;
    @(posedge i_clk) disable iff (!i_resetn)
    (in_m != 4'h0) |=> (o_pin_oe & $past(in_m)) == 4'h0;
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input pin driven by the port");

  property p_periph_in_idle;
    @(posedge i_clk) disable iff (!i_resetn)
    i_resetn |=> (o_periph_in & ~$past(remap_in_m)) == 4'h0;
  endproperty
  a_periph_in_idle: assert property (p_periph_in_idle)
    else $error("peripheral input fed from a pin not routed to it");

  property p_debug_read_zero;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_rd && (i_addr == `PBL_ADDR_PIN) && i_debug_en) |=>
      (o_rdata[3:0] & DEBUG_MASK) == 4'h0;
  endproperty
  a_debug_read_zero: assert property (p_debug_read_zero)
    else $error("debug pin level leaked into a read");

  property p_parallel_no_pullup;
    @(posedge i_clk) disable iff (!i_resetn)
    (par_m != 4'h0) |=> (o_pullup_en & $past(par_m)) == 4'h0;
  endproperty
  a_parallel_no_pullup: assert property (p_parallel_no_pullup)
    else $error("pull-up left on a parallel output pin");

  property p_rdata_idle;
    @(posedge i_clk) disable iff (!i_resetn)
    !i_rd |=> o_rdata == `PBL_RST_RDATA;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data left on the bus outside a read");

endmodule

// ==== rtl/pbl_defines.svh ====
// register offsets, reset values and field positions for the port pins
`ifndef PBL_DEFINES_SVH
`define PBL_DEFINES_SVH

`define PBL_ADDR_W 3
`define PBL_DATA_W 8
`define PBL_NPINS 4

`define PBL_ADDR_DIR 3'h0
`define PBL_ADDR_LAT 3'h1
`define PBL_ADDR_PIN 3'h2
`define PBL_ADDR_ANA 3'h3
`define PBL_ADDR_REMAP 3'h4
`define PBL_ADDR_CTRL 3'h5

`define PBL_RST_DIR 4'hF
`define PBL_RST_LAT 4'h0
`define PBL_RST_DIG 4'h0
`define PBL_RST_REMAP 4'h0
`define PBL_RST_PUDN 1'h1

`define PBL_CTRL_PUDN_BIT 0

`define PBL_RST_OUT 4'h0
`define PBL_RST_OE 4'h0
`define PBL_RST_PU 4'h0
`define PBL_RST_ANA 4'hF
`define PBL_RST_PIN 4'h0
`define PBL_RST_RDATA 8'h00

`endif

// ==== rtl/pbl_pkg.sv ====
// types shared by the port pin logic
package pbl_pkg;

  // software-visible configuration
  typedef struct packed {
    logic [3:0] port_direction;
    logic [3:0] port_output_latch;
    logic [3:0] analog_config_high;
    logic [3:0] remap_select;
    logic pullup_disable_n;
  } pbl_cfg_type;

  // per-pin drive towards the pad
  typedef struct packed {
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pullup_en;
    logic [3:0] analog_en;
    logic [3:0] periph_in;
  } pbl_pad_type;

  // on-chip functions that share the pins
  typedef struct packed {
    logic [3:0] periph_out;
    logic [3:0] parallel_en;
    logic [3:0] parallel_out;
    logic debug_en;
  } pbl_func_type;

endpackage

// ==== rtl/pbl_regs.sv ====
// register file of the port pins, plain strobe bus
`timescale 1ns/1ps
`include "pbl_defines.svh"

module pbl_regs (
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [`PBL_ADDR_W-1:0] i_addr, // register address
  input wire logic [`PBL_DATA_W-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [3:0] i_pin_rd, // gated pin levels
  output logic [`PBL_DATA_W-1:0] o_rdata, // read data, cycle after strobe
  output pbl_pkg::pbl_cfg_type o_cfg // current configuration
);

  pbl_pkg::pbl_cfg_type cfg_r;
  pbl_pkg::pbl_cfg_type cfg_nxt;
  logic [`PBL_DATA_W-1:0] rdata_r;
  logic [`PBL_DATA_W-1:0] rdata_nxt;

  // widen a nibble to the data width, upper bits zero
  function automatic logic [`PBL_DATA_W-1:0] pad4(input logic [3:0] v);
    pad4 = {{(`PBL_DATA_W-4){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------
  // write and read decode
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = `PBL_RST_RDATA;
    if (i_wr) begin
      unique case (i_addr)
        `PBL_ADDR_DIR: cfg_nxt.port_direction = i_wdata[3:0];
        `PBL_ADDR_LAT: cfg_nxt.port_output_latch = i_wdata[3:0];
        `PBL_ADDR_ANA: cfg_nxt.analog_config_high = i_wdata[3:0];
        `PBL_ADDR_REMAP: cfg_nxt.remap_select = i_wdata[3:0];
        `PBL_ADDR_CTRL: begin
          cfg_nxt.pullup_disable_n = i_wdata[`PBL_CTRL_PUDN_BIT];
        end
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        `PBL_ADDR_DIR: rdata_nxt = pad4(cfg_r.port_direction);
        `PBL_ADDR_LAT: rdata_nxt = pad4(cfg_r.port_output_latch);
        `PBL_ADDR_PIN: rdata_nxt = pad4(i_pin_rd);
        `PBL_ADDR_ANA: rdata_nxt = pad4(cfg_r.analog_config_high);
        `PBL_ADDR_REMAP: rdata_nxt = pad4(cfg_r.remap_select);
        `PBL_ADDR_CTRL: begin
          rdata_nxt = `PBL_RST_RDATA;
          rdata_nxt[`PBL_CTRL_PUDN_BIT] = cfg_r.pullup_disable_n;
        end
        default: rdata_nxt = `PBL_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r.port_direction <= `PBL_RST_DIR;
      cfg_r.port_output_latch <= `PBL_RST_LAT;
      cfg_r.analog_config_high <= `PBL_RST_DIG;
      cfg_r.remap_select <= `PBL_RST_REMAP;
      cfg_r.pullup_disable_n <= `PBL_RST_PUDN;
      rdata_r <= `PBL_RST_RDATA;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_cfg = cfg_r;
  assign o_rdata = rdata_r;

endmodule

// ==== rtl/pbl_pin_mux.sv ====
// per-pin function selection of the four port pins
`timescale 1ns/1ps
`include "pbl_defines.svh"

module pbl_pin_mux #(
  parameter logic [3:0] PARALLEL_MASK = 4'hE, // pins with parallel outputs
  parameter logic [3:0] DEBUG_MASK = 4'hF // pins shared with debug
) (
  input pbl_pkg::pbl_cfg_type i_cfg, // configuration
  input pbl_pkg::pbl_func_type i_func, // shared functions
  input wire logic [3:0] i_pin_in, // pad levels
  output pbl_pkg::pbl_pad_type o_pad, // next pad drive
  output logic [3:0] o_pin_rd // gated levels for reads
);

  logic [3:0] dbg;
  logic [3:0] par;
  logic [3:0] dig_en;

  always_comb begin
    dbg = i_func.debug_en ? DEBUG_MASK : 4'h0;
    par = i_func.parallel_en & PARALLEL_MASK & ~dbg;
    dig_en = i_cfg.analog_config_high & ~dbg;
    // parallel outputs ignore the direction bit
    o_pad.pin_oe = ~dbg & (par | ~i_cfg.port_direction);
    // analog selection never enters the output path
    o_pad.pin_out = (par & i_func.parallel_out) |
      (~par & i_cfg.remap_select & i_func.periph_out) |
      (~par & ~i_cfg.remap_select & i_cfg.port_output_latch);
    // pull-up only on pins that are not driven
    o_pad.pullup_en = ~o_pad.pin_oe & ~dbg &
      {4{~i_cfg.pullup_disable_n}};
    o_pad.analog_en = ~i_cfg.analog_config_high & ~dbg;
    o_pad.periph_in = i_cfg.remap_select & i_cfg.port_direction &
      ~par & dig_en & i_pin_in;
    o_pin_rd = i_pin_in & dig_en;
  end

endmodule

// ==== tb/pbl_board.sv ====
// board model: resolved wire level of the four port pins
`timescale 1ns/1ps

module pbl_board (
  input wire logic i_clk, // system clock
  input wire logic [3:0] i_pin_out, // port drive level
  input wire logic [3:0] i_pin_oe, // port drives when high
  input wire logic [3:0] i_pullup_en, // weak pull-up on
  input wire logic [3:0] i_drive_en, // board drives the wire
  input wire logic [3:0] i_drive_val, // board level
  output logic [3:0] o_level // wire level into the port
);
  logic [3:0] float_r = 4'h5;

  // an undriven wire without pull-up never holds a stable value
  always @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      if (i_pin_oe[n]) begin
        o_level[n] = i_pin_out[n];
      end else if (i_drive_en[n]) begin
        o_level[n] = i_drive_val[n];
      end else if (i_pullup_en[n]) begin
        o_level[n] = 1'h1;
      end else begin
        o_level[n] = float_r[n];
      end
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench of the lower-nibble port pins
`timescale 1ns/1ps
`include "pbl_defines.svh"

module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] dir, lat, ana, rem, pud, pe, po, px, dbg, bd, bv;
    logic [3:0] oe, out, pu, an, pi, rd;
  } pbl_row_type;

  logic i_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [3:0] i_periph_out = 4'h0;
  logic [3:0] i_parallel_en = 4'h0;
  logic [3:0] i_parallel_out = 4'h0;
  logic i_debug_en = 1'h0;
  logic [3:0] bd = 4'hF;
  logic [3:0] bv = 4'hF;
  logic [7:0] o_rdata;
  logic [3:0] o_pin_out, o_pin_oe, o_pullup_en, o_analog_en, o_periph_in;
  logic [3:0] level;
  logic [7:0] rd_v;
  int n_mismatch = 0;
  int checks = 0;

  // dir lat ana rem pud pe po px dbg bd bv | oe out pu an pi rd
  pbl_row_type rows [9] = '{
    68'hF_0_0_0_1_0_0_0_0_F_A_0_0_0_F_0_0,
    68'hF_0_F_0_1_0_0_0_0_F_A_0_0_0_0_0_A,
    68'h0_5_0_0_1_0_0_0_0_F_A_F_5_0_F_0_0,
    68'h0_5_F_0_1_0_0_0_0_F_A_F_5_0_0_0_5,
    68'h3_0_F_0_0_0_0_0_0_0_0_C_0_3_0_0_3,
    68'hF_0_F_0_1_F_6_0_0_F_0_E_6_0_0_0_6,
    68'h3_5_F_F_1_0_0_A_0_F_1_C_8_0_0_1_9,
    68'h0_0_F_F_1_2_0_F_0_F_0_F_D_0_0_0_D,
    68'h0_F_F_F_0_E_0_0_1_F_5_0_0_0_0_0_0
  };
  logic [7:0] rst_exp [6] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  always #4 i_clk = ~i_clk;

  pbl_port u_pbl_port (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_in(level), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_pullup_en(o_pullup_en), .o_analog_en(o_analog_en),
    .i_periph_out(i_periph_out), .o_periph_in(o_periph_in),
    .i_parallel_en(i_parallel_en), .i_parallel_out(i_parallel_out),
    .i_debug_en(i_debug_en)
  );

  pbl_board u_pbl_board (
    .i_clk(i_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_drive_en(bd), .i_drive_val(bv),
    .o_level(level)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    d = o_rdata;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_resetn <= 1'h0;
    repeat (2) @(posedge i_clk);
    #1;
    chk({4'h0, o_pin_oe}, 8'h00);
    chk({4'h0, o_pullup_en}, 8'h00);
    chk({4'h0, o_analog_en}, 8'h0F);
    @(posedge i_clk);
    i_resetn <= 1'h1;
    repeat (3) @(posedge i_clk);
    #1;
    chk({4'h0, o_pullup_en}, 8'h00);
    chk({4'h0, o_analog_en}, 8'h0F);
    for (int a = 0; a < 6; a++) begin
      bus_rd(a[2:0], rd_v);
      chk(rd_v, rst_exp[a]);
    end
    $display("reset test done");
  endtask

  task automatic run_row(input pbl_row_type r);
    // software picks digital use before relying on pin reads
    bus_wr(`PBL_ADDR_ANA, {4'h0, r.ana});
    bus_wr(`PBL_ADDR_DIR, {4'h0, r.dir});
    bus_wr(`PBL_ADDR_LAT, {4'h0, r.lat});
    bus_wr(`PBL_ADDR_REMAP, {4'h0, r.rem});
    bus_wr(`PBL_ADDR_CTRL, {4'h0, r.pud});
    @(posedge i_clk);
    i_parallel_en <= r.pe;
    i_parallel_out <= r.po;
    i_periph_out <= r.px;
    i_debug_en <= r.dbg[0];
    bd <= r.bd;
    bv <= r.bv;
    repeat (3) @(posedge i_clk);
    #1;
    chk({4'h0, o_pin_oe}, {4'h0, r.oe});
    chk({4'h0, o_pin_out & o_pin_oe}, {4'h0, r.out});
    chk({4'h0, o_pullup_en}, {4'h0, r.pu});
    chk({4'h0, o_analog_en}, {4'h0, r.an});
    chk({4'h0, o_periph_in & r.rem & ~r.oe}, {4'h0, r.pi});
    bus_rd(`PBL_ADDR_PIN, rd_v);
    chk(rd_v, {4'h0, r.rd});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    $display("row tests done");
    // the last row leaves debug and parallel ownership on
    @(posedge i_clk);
    i_debug_en <= 1'h0;
    i_parallel_en <= 4'h0;
    bus_wr(`PBL_ADDR_DIR, 8'h0F);
    bus_wr(3'h7, 8'h00);
    bus_rd(`PBL_ADDR_DIR, rd_v);
    chk(rd_v, 8'h0F);
    bus_rd(3'h6, rd_v);
    chk(rd_v, 8'h00);
    @(posedge i_clk);
    #1;
    chk(o_rdata, 8'h00);
    bus_wr(`PBL_ADDR_CTRL, 8'hFE);
    bus_rd(`PBL_ADDR_CTRL, rd_v);
    chk(rd_v, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
    chk({4'h0, o_pullup_en}, 8'h0F);
    $display("bus test done");
    do_reset();
    end_of_test();
  end

  // a few hundred cycles are needed; the limit leaves ample margin
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule
